// ===== adc_defs.svh
/*
 Constants of the audio decoder control register bank.
 Assumes inclusion by bare name from the package and the module.
*/
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define ADC_REG_MODE 4'h0
`define ADC_REG_STATUS 4'h1
`define ADC_REG_TONE 4'h2
`define ADC_REG_HDAT1 4'h9
`define ADC_MODE_RESET_VAL 16'h0800
`define ADC_STATUS_RESET_VAL 16'h003C
`define ADC_TONE_RESET_VAL 16'h0000
`define ADC_MODE_WR_MASK 16'h7F7D
`define ADC_STATUS_WR_MASK 16'h000F
`define ADC_BIT_DIFF 0
`define ADC_BIT_RESET 2
`define ADC_BIT_ABORT 3
`define ADC_BIT_PDOWN 4
`define ADC_BIT_TESTS 5
`define ADC_BIT_STREAM 6
`define ADC_BIT_DACT 8
`define ADC_BIT_SDIORD 9
`define ADC_BIT_SHARE 10
`define ADC_BIT_NATIVE 11
`define ADC_BIT_REC 12
`define ADC_BIT_RECHP 13
`define ADC_BIT_RECSRC 14
`define ADC_RESET_XTAL_CYCLES 16600
`define ADC_XFER_BITS 16
`define ADC_CMD_READ 8'h03
`define ADC_CMD_WRITE 8'h02
`endif

// ===== adc_pkg.sv
/*
 Types of the audio decoder control register bank.
 Assumes adc_defs.svh is on the include path.
*/
package adc_pkg;
`include "adc_defs.svh"
   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [15:0] data;
   } adc_req_type;
   typedef enum logic [2:0] {
      ADC_IDLE = 3'b001,
      ADC_HOLD = 3'b010,
      ADC_DONE = 3'b100
   } adc_rst_state_type;
endpackage

// ===== adc_ctrl_regs.sv
/*
 Control, status and tone registers behind a serial control port.
 Assumes a host sending 8-bit command, 8-bit address, 16-bit data, mode 0,
 on its own clock sck while cs_n is low; firmware side on core_clk.
*/
`timescale 1ns/10ps
`include "adc_defs.svh"
module adc_ctrl_regs
   import adc_pkg::*;
#(
   // Version value is arbitrary
   parameter logic [2:0] VERSION_CODE = 3'h5,
   parameter int RESET_HOLD_CYCLES = `ADC_RESET_XTAL_CYCLES
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic abort_done,
   input wire logic [1:0] fw_attenuation,
   input wire logic fw_attn_load,
   output logic left_invert_en,
   output logic soft_reset_pulse,
   output logic soft_powerdown,
   output logic test_enable,
   output logic stream_mode_en,
   output logic data_clock_edge,
   output logic data_bit_order,
   output logic shared_cs_active,
   output logic native_serial_mode,
   output logic record_start,
   output logic record_highpass,
   output logic record_source_sel,
   output logic header_hi_clear,
   output logic data_request,
   output logic analog_driver_pd,
   output logic analog_internal_pd,
   output logic [1:0] analog_attenuation,
   output logic bass_active,
   output logic treble_active,
   output logic [3:0] bass_gain,
   output logic [3:0] bass_corner,
   output logic [3:0] treble_gain,
   output logic [3:0] treble_corner
);

   localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // Link side, clocked by sck

   logic [4:0] bit_cnt_r;
   logic [31:0] sh_r;
   logic [15:0] rd_word_r;
   logic req_tgl_r;
   adc_req_type req_r;
   logic [15:0] snap_mode_r;
   logic [15:0] snap_status_r;
   logic [15:0] snap_tone_r;
   logic [15:0] mode_r;
   logic [15:0] status_r;
   logic [15:0] tone_r;
   logic miso_r;
   logic [31:0] sh_nxt;

   assign sh_nxt = {sh_r[30:0], mosi};

   function automatic logic [15:0] adc_read_sel(input logic [3:0] a,
                                                input logic [15:0] m,
                                                input logic [15:0] s,
                                                input logic [15:0] t);
      case (a)
         `ADC_REG_MODE: adc_read_sel = m;
         `ADC_REG_STATUS: adc_read_sel = s;
         `ADC_REG_TONE: adc_read_sel = t;
         default: adc_read_sel = 16'h0000;
      endcase
   endfunction

   // Frame ends with cs_n; no sck edge counted outside a frame
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_r <= 5'h00;
      end else if (bit_cnt_r != 5'h1F) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge sck) begin
      sh_r <= sh_nxt;
   end

   logic frame_wr;
   assign frame_wr = !cs_n && bit_cnt_r == 5'h1F && sh_nxt[31:24] == `ADC_CMD_WRITE;

   always_ff @(posedge sck) begin
      if (frame_wr) begin
         req_r <= '{wr: 1'b1, addr: sh_nxt[19:16], data: sh_nxt[15:0]};
      end
   end

   // Toggle cleared with the core so both ends of the sync start equal
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         req_tgl_r <= 1'b0;
      end else if (frame_wr) begin
         req_tgl_r <= ~req_tgl_r;
      end
   end

   // Register snapshot for reads, sampled at address completion
   always_ff @(posedge sck) begin
      if (!cs_n && bit_cnt_r == 5'h0F) begin
         rd_word_r <= adc_read_sel(sh_nxt[3:0], snap_mode_r, snap_status_r, snap_tone_r);
      end else if (bit_cnt_r >= 5'h10) begin
         rd_word_r <= {rd_word_r[14:0], 1'b0};
      end
   end

   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         miso_r <= 1'b0;
      end else begin
         miso_r <= rd_word_r[15];
      end
   end

   // Two-stage capture of register values into the link domain
   logic [47:0] snap_s1_r;
   always_ff @(posedge sck) begin
      snap_s1_r <= {mode_r, status_r, tone_r};
      {snap_mode_r, snap_status_r, snap_tone_r} <= snap_s1_r;
   end

   assign miso = miso_r;
   assign miso_oe = ~cs_n;

   ////////////////////////////////////////////////////////////////////////
   // Core side: request crossing

   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic wr_stb;
   logic [3:0] wr_addr;
   logic [15:0] wr_data;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
      end else begin
         tgl_s1_r <= req_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   // Payload is stable for many core cycles once toggle seen
   assign wr_stb = tgl_s2_r ^ tgl_s3_r;
   assign wr_addr = req_r.addr;
   assign wr_data = req_r.data;

   logic abort_s1_r;
   logic abort_s2_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         abort_s1_r <= 1'b0;
         abort_s2_r <= 1'b0;
      end else begin
         abort_s1_r <= abort_done;
         abort_s2_r <= abort_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Soft reset sequencer

   adc_rst_state_type rst_state_r;
   logic [HOLD_W-1:0] hold_cnt_r;
   logic soft_req;

   assign soft_req = wr_stb && wr_addr == `ADC_REG_MODE && wr_data[`ADC_BIT_RESET];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rst_state_r <= ADC_IDLE;
         hold_cnt_r <= '0;
      end else begin
         case (rst_state_r)
            ADC_IDLE: begin
               if (soft_req) begin
                  rst_state_r <= ADC_HOLD;
                  hold_cnt_r <= HOLD_W'(RESET_HOLD_CYCLES - 1);
               end
            end
            ADC_HOLD: begin
               if (hold_cnt_r == '0) begin
                  rst_state_r <= ADC_DONE;
               end else begin
                  hold_cnt_r <= hold_cnt_r - 1'b1;
               end
            end
            ADC_DONE: rst_state_r <= ADC_IDLE;
            default: rst_state_r <= ADC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // bits 1, 7 and 15 kept at zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_r <= `ADC_MODE_RESET_VAL;
      end else begin
         if (wr_stb && wr_addr == `ADC_REG_MODE) begin
            mode_r <= wr_data & `ADC_MODE_WR_MASK;
         end
         if (rst_state_r == ADC_DONE) begin
            mode_r[`ADC_BIT_RESET] <= 1'b0;
         end
         if (abort_s2_r) begin
            mode_r[`ADC_BIT_ABORT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_r <= `ADC_STATUS_RESET_VAL;
      end else begin
         if (wr_stb && wr_addr == `ADC_REG_STATUS) begin
            status_r <= wr_data & `ADC_STATUS_WR_MASK;
         end else if (fw_attn_load) begin
            status_r[1:0] <= fw_attenuation;
         end
         status_r[6:4] <= VERSION_CODE;
         status_r[15:7] <= 9'h000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tone_r <= `ADC_TONE_RESET_VAL;
      end else if (wr_stb && wr_addr == `ADC_REG_TONE) begin
         tone_r <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge core_clk) begin
      if (rst) begin
         left_invert_en <= 1'b0;
         soft_powerdown <= 1'b0;
         test_enable <= 1'b0;
         stream_mode_en <= 1'b0;
         data_clock_edge <= 1'b0;
         data_bit_order <= 1'b0;
         shared_cs_active <= 1'b0;
         native_serial_mode <= 1'b1;
         record_source_sel <= 1'b0;
      end else begin
         left_invert_en <= mode_r[`ADC_BIT_DIFF];
         soft_powerdown <= mode_r[`ADC_BIT_PDOWN];
         test_enable <= mode_r[`ADC_BIT_TESTS];
         stream_mode_en <= mode_r[`ADC_BIT_STREAM];
         data_clock_edge <= mode_r[`ADC_BIT_DACT];
         data_bit_order <= mode_r[`ADC_BIT_SDIORD];
         shared_cs_active <= mode_r[`ADC_BIT_SHARE] & mode_r[`ADC_BIT_NATIVE];
         native_serial_mode <= mode_r[`ADC_BIT_NATIVE];
         record_source_sel <= mode_r[`ADC_BIT_RECSRC];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         soft_reset_pulse <= 1'b0;
         record_start <= 1'b0;
         record_highpass <= 1'b0;
         header_hi_clear <= 1'b0;
         data_request <= 1'b0;
      end else begin
         soft_reset_pulse <= soft_req;
         record_start <= soft_req & wr_data[`ADC_BIT_REC];
         if (soft_req) begin
            record_highpass <= wr_data[`ADC_BIT_REC] & wr_data[`ADC_BIT_RECHP];
         end
         header_hi_clear <= abort_s2_r & mode_r[`ADC_BIT_ABORT];
         // Rises as the hold ends, so it stays low exactly the hold length
         data_request <= (rst_state_r == ADC_IDLE && !soft_req)
            || (rst_state_r == ADC_HOLD && hold_cnt_r == '0)
            || rst_state_r == ADC_DONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         analog_driver_pd <= 1'b1;
         analog_internal_pd <= 1'b1;
         analog_attenuation <= 2'h0;
      end else begin
         analog_driver_pd <= status_r[3];
         analog_internal_pd <= status_r[2];
         analog_attenuation <= status_r[1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bass_active <= 1'b0;
         treble_active <= 1'b0;
         bass_gain <= 4'h0;
         bass_corner <= 4'h0;
         treble_gain <= 4'h0;
         treble_corner <= 4'h0;
      end else begin
         bass_active <= tone_r[7:4] != 4'h0;
         bass_gain <= tone_r[7:4];
         bass_corner <= tone_r[3:0];
         treble_active <= tone_r[15:12] != 4'h0;
         treble_gain <= tone_r[15:12];
         treble_corner <= tone_r[11:8];
      end
   end

endmodule

// ===== adc_host_model.sv
/*
 Host master of the serial control port, sending one frame per xfer call.
 Assumes the bench calls xfer; sck runs only inside frames, 160 ns period.
*/
`timescale 1ns/10ps
module adc_host_model (
   output logic sck,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   ////////////////////////////////////////
   // sixteen data bits
   task automatic xfer(input logic [7:0] cmd, input logic [3:0] addr,
                       input logic [15:0] wdata, output logic [15:0] rdata);
      logic [31:0] frame;
      frame = {cmd, 4'h0, addr, wdata};
      rdata = 16'h0000;
      #13 cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = frame[i];
         #80 sck = 1'b1;
         if (i < 16) rdata[i] = miso;
         #80 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      // Released line shows the inverse of its last value
      mosi = ~mosi;
      #200;
   endtask
endmodule

// ===== adc_ctrl_regs_assertions.sv
/*
 Port checks of the control register bank, bound to its top module.
 Assumes only the core_clk domain is sampled; rst is synchronous.
*/
`timescale 1ns/10ps
module adc_ctrl_regs_assertions
   import adc_pkg::*;
#(
   parameter int RESET_HOLD_CYCLES = 8
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic miso_oe,
   input wire logic abort_done,
   input wire logic [1:0] fw_attenuation,
   input wire logic fw_attn_load,
   input wire logic soft_reset_pulse,
   input wire logic record_start,
   input wire logic header_hi_clear,
   input wire logic data_request,
   input wire logic shared_cs_active,
   input wire logic native_serial_mode,
   input wire logic analog_driver_pd,
   input wire logic [1:0] analog_attenuation,
   input wire logic bass_active,
   input wire logic treble_active,
   input wire logic [3:0] bass_gain,
   input wire logic [3:0] treble_gain
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   int lo_cnt_r;
   logic armed_r;
   ////////////////////////////////////////
   // Low run of data request, armed by a soft reset
   always_ff @(posedge core_clk) begin
      if (rst || data_request) lo_cnt_r <= 0;
      else lo_cnt_r <= lo_cnt_r + 1;
   end
   always_ff @(posedge core_clk) begin
      if (rst) armed_r <= 1'b0;
      else if (soft_reset_pulse) armed_r <= 1'b1;
      else if ($rose(data_request)) armed_r <= 1'b0;
   end
   sequence req_drop;
      ##[0:2] !data_request;
   endsequence
   a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   a_reset_data_request_drop: assert property (soft_reset_pulse |-> req_drop)
      else $error("data request did not drop after soft reset");
   a_hold_length: assert property ($rose(data_request) && armed_r |-> lo_cnt_r == RESET_HOLD_CYCLES)
      else $error("data request low time wrong");
   a_record_cause: assert property (record_start |-> soft_reset_pulse || $past(soft_reset_pulse))
      else $error("record start without soft reset");
   a_share_native: assert property (shared_cs_active |-> native_serial_mode)
      else $error("shared select without native mode");
   a_bass_flag: assert property (bass_active == (bass_gain != 4'h0))
      else $error("bass active flag wrong");
   a_treble_flag: assert property (treble_active == (treble_gain != 4'h0))
      else $error("treble active flag wrong");
   a_frame_drive: assert property (miso_oe == !cs_n)
      else $error("miso enable not tied to frame");
   a_abort_cause: assert property (header_hi_clear |-> $past(abort_done) || $past(abort_done, 2)
      || $past(abort_done, 3) || $past(abort_done, 4))
      else $error("header clear without abort done");
   a_attn_load: assert property (fw_attn_load |-> ##2 analog_attenuation == $past(fw_attenuation, 2))
      else $error("attenuation load not seen");
   a_native_start: assert property ($fell(rst) |-> native_serial_mode && analog_driver_pd)
      else $error("startup mode bits wrong");
endmodule
bind adc_ctrl_regs adc_ctrl_regs_assertions #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES))
   adc_ctrl_regs_assertions_inst (.*);

// ===== test_adc_ctrl_regs.sv
/*
 Self-checking bench of the control register bank against a bench model.
 Assumes package, design, host model and checker compiled before it.
*/
`timescale 1ns/10ps
module test_adc_ctrl_regs;
   import adc_pkg::*;
   localparam int HOLD = 8;
   localparam logic [2:0] VER = 3'h5;
   logic core_clk = 1'b0, rst = 1'b1, abort_done = 1'b0, fw_attn_load = 1'b0;
   logic sck, cs_n, mosi, miso, miso_oe, left_invert_en, soft_reset_pulse, soft_powerdown;
   logic test_enable, stream_mode_en, data_clock_edge, data_bit_order, shared_cs_active;
   logic native_serial_mode, record_start, record_highpass, record_source_sel, header_hi_clear;
   logic data_request, analog_driver_pd, analog_internal_pd, bass_active, treble_active;
   logic [1:0] fw_attenuation = 2'h0, analog_attenuation;
   logic [3:0] bass_gain, bass_corner, treble_gain, treble_corner, a;
   logic [15:0] mode_m = 16'h0800, stat_m = {9'h000, VER, 4'hC}, tone_m = 16'h0000, rd, d;
   int err_total = 0, checks = 0, cyc = 0, seed = 75959;
   int sr_cnt = 0, rs_cnt = 0, hc_cnt = 0, lo_run = 0, last_lo = 0;
   always #4 core_clk = ~core_clk;
   adc_ctrl_regs #(.VERSION_CODE(VER), .RESET_HOLD_CYCLES(HOLD)) adc_ctrl_regs_inst (.*);
   adc_host_model adc_host_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   ////////////////////////////////////////
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      sr_cnt <= sr_cnt + int'(soft_reset_pulse);
      rs_cnt <= rs_cnt + int'(record_start);
      hc_cnt <= hc_cnt + int'(header_hi_clear);
      if (data_request !== 1'b1) lo_run <= lo_run + 1;
      else begin
         if (lo_run != 0) last_lo <= lo_run;
         lo_run <= 0;
      end
      if (cyc == 40000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
      adc_host_model_inst.xfer(8'h02, ad, wd, rd);
      if (ad == 4'h0) mode_m = wd & 16'h7F7D;
      if (ad == 4'h1) stat_m = {9'h000, VER, wd[3:0]};
      if (ad == 4'h2) tone_m = wd;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic rdc(input logic [3:0] ad);
      adc_host_model_inst.xfer(8'h03, ad, 16'h0000, rd);
      chk("register", ad == 0 ? mode_m : ad == 1 ? stat_m : ad == 2 ? tone_m : 16'h0000, rd);
   endtask
   task automatic outs();
      chk("mode_outputs", {7'h00, mode_m[14], mode_m[10] & mode_m[11], mode_m[11], mode_m[9],
         mode_m[8], mode_m[6], mode_m[5], mode_m[4], mode_m[0]}, {7'h00, record_source_sel,
         shared_cs_active, native_serial_mode, data_bit_order, data_clock_edge, stream_mode_en,
         test_enable, soft_powerdown, left_invert_en});
      chk("tone_outputs", tone_m, {treble_gain, treble_corner, bass_gain, bass_corner});
      chk("flags", {10'h000, |tone_m[15:12], |tone_m[7:4], stat_m[3:0]}, {10'h000, treble_active,
         bass_active, analog_driver_pd, analog_internal_pd, analog_attenuation});
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      for (int i = 0; i < 3; i++) rdc(i[3:0]);
      outs();
      $display("test reset_values done");
      for (int i = 0; i < 8; i++) begin
         a = {2'b00, i[1:0]};
         if (a == 4'h3) a = 4'hD;
         d = 16'($random(seed));
         // host keeps bits 1, 2, 3 and 7 zero
         if (a == 4'h0) d = d & 16'hFF71;
         wr(a, d);
         rdc(a);
         if (a == 4'hD) rdc(4'h0);
         outs();
      end
      $display("test random_writes done");
      wr(4'h0, mode_m | 16'h3004);
      mode_m = mode_m & 16'hFFFB;
      for (int k = 0; k < 300 && data_request !== 1'b1; k++) @(posedge core_clk);
      chk("reset_pulses", 16'd1, 16'(sr_cnt));
      chk("record_start", 16'd1, 16'(rs_cnt));
      chk("record_highpass", 16'd1, {15'h0000, record_highpass});
      chk("hold_cycles", 16'(HOLD), 16'(last_lo));
      rdc(4'h0);
      $display("test soft_reset done");
      wr(4'h0, 16'h0808);
      rdc(4'h0);
      abort_done <= 1'b1;
      repeat (6) @(posedge core_clk);
      abort_done <= 1'b0;
      repeat (6) @(posedge core_clk);
      mode_m = 16'h0800;
      chk("header_clear", 16'd1, 16'(hc_cnt));
      rdc(4'h0);
      $display("test abort done");
      for (int i = 0; i < 3; i++) begin
         fw_attenuation <= (i == 2) ? 2'h0 : 2'(i * 2 + 1);
         fw_attn_load <= 1'b1;
         @(posedge core_clk);
         fw_attn_load <= 1'b0;
         repeat (3) @(posedge core_clk);
         stat_m[1:0] = fw_attenuation;
         outs();
         rdc(4'h1);
      end
      $display("test attenuation done");
      wr(4'h1, 16'h0008);
      outs();
      repeat (50) @(posedge core_clk);
      rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      mode_m = 16'h0800;
      stat_m = {9'h000, VER, 4'hC};
      tone_m = 16'h0000;
      repeat (6) @(posedge core_clk);
      chk("highpass_reset", 16'h0000, {15'h0000, record_highpass});
      for (int i = 0; i < 3; i++) rdc(i[3:0]);
      outs();
      $display("test mid_reset done");
      stop_test();
   end
endmodule
